/* File: core/b4s_pkg.sv */
// What this block does
// - Select bit clear: normal code drives output unless strap low and pin picks scaled
// - Select bit set: scaled code drives output
// - Normal register top bit reads zero
// - Scaled top bit enables converter; sequencer sets
// - Low quiescent only while mode control clear
// - Span code maps code to voltage
// - Codes above ceiling replaced; ceiling locks unless open (3f) or zero (00)
// - Power-on reset restores default contents
package b4s_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_NORMAL = 8'h0d;
    localparam logic [7:0] ADDR_SCALED = 8'h0e;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int RSVD_BIT = 7;
    localparam int SRC_SEL_BIT = 6;
    localparam int ENABLE_BIT = 7;
    localparam int LOWQ_BIT = 6;
    localparam int CODE_W = 6;

    // ------------------------------------------------------------
    // Reset values and ceiling markers
    // ------------------------------------------------------------
    localparam logic [7:0] NORMAL_RESET = 8'h00;
    localparam logic [7:0] SCALED_RESET = 8'h00;
    localparam logic [5:0] CEIL_OPEN = 6'h3f;
    localparam logic [5:0] CEIL_ZERO = 6'h00;

    // ------------------------------------------------------------
    // Span encodings and voltage steps in microvolts
    // ------------------------------------------------------------
    localparam logic [1:0] SPAN_FINE_LOW = 2'h0;
    localparam logic [1:0] SPAN_FINE_HIGH = 2'h1;
    localparam logic [1:0] SPAN_MID = 2'h2;
    localparam logic [1:0] SPAN_WIDE = 2'h3;
    localparam logic [21:0] BASE_LOW_UV = 22'd500000;
    localparam logic [21:0] BASE_HIGH_UV = 22'd700000;
    localparam logic [21:0] STEP_FINE_UV = 22'd12500;
    localparam logic [21:0] STEP_MID_UV = 22'd25000;
    localparam logic [21:0] STEP_WIDE_UV = 22'd50000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } b4s_req_t;

    typedef struct packed {
        logic enable;
        logic lowQuiescent;
        logic useScaled;
        logic [5:0] code;
    } b4s_ctrl_t;

    function automatic logic [5:0] b4s_clamp(
        input logic [5:0] code,
        input logic [5:0] ceiling
    );
        b4s_clamp = (code > ceiling) ? ceiling : code;
    endfunction

endpackage

/* File: core/b4s_volt_map.sv */
`timescale 1ns/10ps
module b4s_volt_map
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [1:0] span,
    input wire logic [5:0] code,
    output logic [21:0] microvolts
);
    import b4s_pkg::*;

    logic [21:0] next_microvolts;

    always_comb
    begin
        case (span)
            SPAN_FINE_LOW: next_microvolts = BASE_LOW_UV
                + 22'(code) * STEP_FINE_UV;
            SPAN_FINE_HIGH: next_microvolts = BASE_HIGH_UV
                + 22'(code) * STEP_FINE_UV;
            SPAN_MID: next_microvolts = BASE_LOW_UV
                + 22'(code) * STEP_MID_UV;
            default: next_microvolts = BASE_LOW_UV
                + 22'(code) * STEP_WIDE_UV;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            microvolts <= BASE_LOW_UV;
        else
            microvolts <= next_microvolts;
    end

    chk_wide_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        span == SPAN_WIDE |=> microvolts ==
            BASE_LOW_UV + 22'($past(code)) * STEP_WIDE_UV)
        else $error("wide span voltage wrong");

    chk_high_base: assert property (@(posedge sys_clk) disable iff (!rstn)
        span == SPAN_FINE_HIGH && code == 6'h00
        |=> microvolts == BASE_HIGH_UV)
        else $error("high fine span base wrong");

endmodule // b4s_volt_map

/* File: core/b4s_setpoint_regs.sv */
`timescale 1ns/10ps
module b4s_setpoint_regs #(
    parameter logic [7:0] NORMAL_DEFAULT = b4s_pkg::NORMAL_RESET,
    parameter logic [7:0] SCALED_DEFAULT = b4s_pkg::SCALED_RESET,
    parameter bit SEQ_VARIANT = 1'b1
)(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire b4s_pkg::b4s_req_t regReq,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic boardStrap,
    input wire logic voltageChoice,
    input wire logic modeControl,
    input wire logic [1:0] spanCode,
    input wire logic [5:0] ceilingCode,
    input wire logic seqPowerUp,
    output b4s_pkg::b4s_ctrl_t convCtrl,
    output logic [21:0] targetMicrovolts,
    output logic limitLocked
);
    import b4s_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NORMAL_DEFAULT[RSVD_BIT] != 1'b0)
        $error("normal default must keep its unused bit clear");

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstMeta;
    logic rstn;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rstMeta <= 1'b0;
            rstn <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstn <= rstMeta;
        end
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic wrNormal;
    logic wrScaled;
    logic [5:0] wrCode;

    assign wrNormal = regReq.wr && regReq.addr == ADDR_NORMAL;
    assign wrScaled = regReq.wr && regReq.addr == ADDR_SCALED;
    assign wrCode = b4s_clamp(regReq.data[CODE_W-1:0], ceilingCode);

    // ------------------------------------------------------------
    // Normal setpoint register
    // ------------------------------------------------------------
    logic srcSelect;
    logic [5:0] normalCode;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            srcSelect <= NORMAL_DEFAULT[SRC_SEL_BIT];
            normalCode <= NORMAL_DEFAULT[CODE_W-1:0];
        end
        else if (wrNormal)
        begin
            // Unused top bit is dropped, whatever is written
            srcSelect <= regReq.data[SRC_SEL_BIT];
            normalCode <= wrCode;
        end
    end

    // ------------------------------------------------------------
    // Scaled setpoint register
    // ------------------------------------------------------------
    logic convEnable;
    logic lowQuiescentBit;
    logic [5:0] scaledCode;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            convEnable <= SCALED_DEFAULT[ENABLE_BIT];
            lowQuiescentBit <= SCALED_DEFAULT[LOWQ_BIT];
            scaledCode <= SCALED_DEFAULT[CODE_W-1:0];
        end
        else
        begin
            if (wrScaled)
            begin
                lowQuiescentBit <= regReq.data[LOWQ_BIT];
                scaledCode <= wrCode;
            end
            // Sequencer wins over a host write in the same cycle
            if (SEQ_VARIANT && seqPowerUp)
                convEnable <= 1'b1;
            else if (wrScaled)
                convEnable <= regReq.data[ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    logic [7:0] next_rdData;

    always_comb
    begin
        case (regReq.addr)
            ADDR_NORMAL: next_rdData = {1'b0, srcSelect, normalCode};
            ADDR_SCALED: next_rdData = {convEnable, lowQuiescentBit,
                scaledCode};
            default: next_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            regRdData <= 8'h00;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regReq.rd;
            if (regReq.rd)
                regRdData <= next_rdData;
        end
    end

    // ------------------------------------------------------------
    // Source choice and converter control
    // ------------------------------------------------------------
    // The pin only counts while the strap is low; software
    // should then keep the select bit clear or it overrides
    logic pinPicksScaled;
    logic useScaled;
    b4s_ctrl_t next_ctrl;

    assign pinPicksScaled = !boardStrap && voltageChoice;
    assign useScaled = srcSelect || pinPicksScaled;

    always_comb
    begin
        next_ctrl.enable = convEnable;
        next_ctrl.lowQuiescent = lowQuiescentBit && !modeControl;
        next_ctrl.useScaled = useScaled;
        next_ctrl.code = useScaled ? scaledCode : normalCode;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            convCtrl <= '0;
            limitLocked <= 1'b0;
        end
        else
        begin
            convCtrl <= next_ctrl;
            limitLocked <= ceilingCode != CEIL_OPEN
                && ceilingCode != CEIL_ZERO;
        end
    end

    b4s_volt_map u_volt_map (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .span(spanCode),
        .code(next_ctrl.code),
        .microvolts(targetMicrovolts)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_wrNormal;
        regReq.wr && regReq.addr == ADDR_NORMAL;
    endsequence

    sequence s_rdNormal;
        regReq.rd && !regReq.wr && regReq.addr == ADDR_NORMAL;
    endsequence

    sequence s_wrScaledHi;
        regReq.wr && regReq.addr == ADDR_SCALED
            && regReq.data[CODE_W-1:0] > ceilingCode;
    endsequence

    chk_pick_normal: assert property (@(posedge sys_clk) disable iff (!rstn)
        !srcSelect && !pinPicksScaled
        |=> convCtrl.code == $past(normalCode))
        else $error("normal code not selected");

    chk_pick_scaled: assert property (@(posedge sys_clk) disable iff (!rstn)
        srcSelect |=> convCtrl.useScaled
            && convCtrl.code == $past(scaledCode))
        else $error("scaled code not selected");

    chk_rsvd_reads: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_rdNormal |=> regRdValid && regRdData[RSVD_BIT] == 1'b0)
        else $error("unused bit read as one");

    chk_normal_back: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_wrNormal ##1 s_rdNormal |=> regRdData[CODE_W-1:0]
            == b4s_clamp($past(regReq.data[CODE_W-1:0], 2),
                $past(ceilingCode, 2)))
        else $error("normal code read-back wrong");

    chk_seq_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
        SEQ_VARIANT && seqPowerUp |=> convEnable ##1 convCtrl.enable)
        else $error("sequencer did not enable");

    chk_lowq_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
        modeControl |=> !convCtrl.lowQuiescent)
        else $error("low quiescent while mode control set");

    chk_lowq_on: assert property (@(posedge sys_clk) disable iff (!rstn)
        lowQuiescentBit && !modeControl |=> convCtrl.lowQuiescent)
        else $error("low quiescent not applied");

    chk_ceil_clamp: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_wrScaledHi |=> scaledCode == $past(ceilingCode))
        else $error("code above ceiling kept");

    chk_reset_load: assert property (@(posedge sys_clk)
        !rstn |=> !rstn || (normalCode == NORMAL_DEFAULT[CODE_W-1:0]
            && scaledCode == SCALED_DEFAULT[CODE_W-1:0]))
        else $error("defaults not restored");

endmodule // b4s_setpoint_regs

/* File: dv/tb_buck4_setpoint_select_regs.sv */
`timescale 1ns/10ps
module tb_buck4_setpoint_select_regs;
    import b4s_pkg::*;

    // ------------------------------------------------------------
    // Comparison helper
    // ------------------------------------------------------------
    `define CHK(got, exp, msg) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_mismatch++; \
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp); \
        end \
    end

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    b4s_req_t regReq = '0;
    logic [7:0] regRdData;
    logic regRdValid;
    logic boardStrap = 1'b1;
    logic voltageChoice = 1'b0;
    logic modeControl = 1'b0;
    logic seqPowerUp = 1'b0;
    logic [1:0] spanCode = 2'h0;
    logic [5:0] ceilingCode = 6'h3f;
    b4s_ctrl_t convCtrl;
    logic [21:0] targetMicrovolts;
    logic limitLocked;
    logic [7:0] expQ[$];
    logic [7:0] expRd;
    logic [15:0] lfsrState = 16'hcd4b;
    logic [5:0] code;
    logic [21:0] expUv;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    b4s_setpoint_regs u_dut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .regReq(regReq),
        .regRdData(regRdData),
        .regRdValid(regRdValid),
        .boardStrap(boardStrap),
        .voltageChoice(voltageChoice),
        .modeControl(modeControl),
        .spanCode(spanCode),
        .ceilingCode(ceilingCode),
        .seqPowerUp(seqPowerUp),
        .convCtrl(convCtrl),
        .targetMicrovolts(targetMicrovolts),
        .limitLocked(limitLocked)
    );

    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge sys_clk);
        regReq = '{wr: w, rd: !w, addr: a, data: d};
        @(negedge sys_clk);
        regReq = '0;
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        access(1'b0, a, 8'h00);
    endtask

    // Write then read back on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d,
                         input logic [7:0] e);
        expQ.push_back(e);
        @(negedge sys_clk);
        regReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge sys_clk);
        regReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(negedge sys_clk);
        regReq = '0;
    endtask

    // Register, then output stage, plus margin
    task settle;
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic ctrl_chk(input logic en, input logic lq, input logic us,
                            input logic [5:0] c);
        settle;
        `CHK(convCtrl, b4s_ctrl_t'({en, lq, us, c}), "ctrl")
    endtask

    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Read monitor and hang guard
    // ------------------------------------------------------------
    // An unexpected read pulls x, which never matches
    always @(negedge sys_clk)
        if (regRdValid === 1'b1)
        begin
            expRd = (expQ.size() != 0) ? expQ.pop_front() : 8'hxx;
            `CHK(regRdData, expRd, "read")
        end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            $display("BAD t=%0t timeout", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        settle;
        rd_exp(ADDR_NORMAL, NORMAL_RESET);
        rd_exp(ADDR_SCALED, SCALED_RESET);
        ctrl_chk(1'b0, 1'b0, 1'b0, 6'h00);
        $display("test reset done");
        access(1'b1, ADDR_SCALED, 8'h8a);
        access(1'b1, ADDR_NORMAL, 8'hc5);
        rd_exp(ADDR_NORMAL, 8'h45);
        ctrl_chk(1'b1, 1'b0, 1'b1, 6'h0a);
        access(1'b1, ADDR_NORMAL, 8'h05);
        ctrl_chk(1'b1, 1'b0, 1'b0, 6'h05);
        $display("test select done");
        boardStrap = 1'b0;
        voltageChoice = 1'b1;
        ctrl_chk(1'b1, 1'b0, 1'b1, 6'h0a);
        voltageChoice = 1'b0;
        ctrl_chk(1'b1, 1'b0, 1'b0, 6'h05);
        boardStrap = 1'b1;
        voltageChoice = 1'b1;
        ctrl_chk(1'b1, 1'b0, 1'b0, 6'h05);
        $display("test strap done");
        access(1'b1, ADDR_SCALED, 8'hca);
        ctrl_chk(1'b1, 1'b1, 1'b0, 6'h05);
        modeControl = 1'b1;
        ctrl_chk(1'b1, 1'b0, 1'b0, 6'h05);
        rd_exp(ADDR_SCALED, 8'hca);
        modeControl = 1'b0;
        $display("test low quiescent done");
        access(1'b1, ADDR_SCALED, 8'h0a);
        ctrl_chk(1'b0, 1'b0, 1'b0, 6'h05);
        @(negedge sys_clk) seqPowerUp = 1'b1;
        @(negedge sys_clk) seqPowerUp = 1'b0;
        ctrl_chk(1'b1, 1'b0, 1'b0, 6'h05);
        rd_exp(ADDR_SCALED, 8'h8a);
        $display("test enable done");
        ceilingCode = 6'h10;
        wr_rd(ADDR_NORMAL, 8'h3f, 8'h10);
        wr_rd(ADDR_SCALED, 8'hbf, 8'h90);
        `CHK(limitLocked, 1'b1, "lock")
        ceilingCode = 6'h00;
        access(1'b1, ADDR_NORMAL, 8'h07);
        rd_exp(ADDR_NORMAL, 8'h00);
        `CHK(limitLocked, 1'b0, "lock")
        ceilingCode = 6'h3f;
        access(1'b1, 8'h0f, 8'h55);
        rd_exp(8'h0f, 8'h00);
        `CHK(limitLocked, 1'b0, "lock")
        $display("test ceiling done");
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 3; k++)
            begin
                lfsrState = lfsr_next(lfsrState);
                // First pass of each span hits its base voltage
                code = (k == 0) ? 6'h00 : lfsrState[5:0];
                spanCode = 2'(s);
                access(1'b1, ADDR_NORMAL, {2'b00, code});
                settle;
                expUv = ((s == 1) ? BASE_HIGH_UV : BASE_LOW_UV) + 22'(code)
                    * ((s == 3) ? STEP_WIDE_UV
                    : (s == 2) ? STEP_MID_UV : STEP_FINE_UV);
                `CHK(targetMicrovolts, expUv, "volt")
            end
        $display("test span done");
        resetn = 1'b0;
        repeat (2) @(negedge sys_clk);
        resetn = 1'b1;
        settle;
        rd_exp(ADDR_SCALED, SCALED_RESET);
        ctrl_chk(1'b0, 1'b0, 1'b0, 6'h00);
        settle;
        `CHK(expQ.size(), 0, "pending reads")
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // tb_buck4_setpoint_select_regs
